// ===== hw/pfc_pkg.sv
// Constants of the program flow unit: register map, fields, codes.
// Assumes a 32-bit APB master and an 8-bit memory bus outside.
package pfc_pkg;
	localparam logic [7:0] OFS_COMMAND         = 8'h00;
	localparam logic [7:0] OFS_STATUS          = 8'h04;
	localparam logic [7:0] OFS_FLAGS           = 8'h08;
	localparam logic [7:0] OFS_LOOP_COUNT      = 8'h0c;
	localparam logic [7:0] OFS_PROGRAM_COUNTER = 8'h10;
	localparam logic [7:0] OFS_STACK_POINTER   = 8'h14;
	localparam logic [7:0] OFS_OPERAND         = 8'h18;

	localparam int CMD_OP_LSB  = 0;
	localparam int CMD_CC_LSB  = 4;
	localparam int STAT_BUSY   = 0;
	localparam int STAT_TAKEN  = 1;
	localparam int STAT_BADCC  = 2;
	localparam int FLAG_SIGN   = 7;
	localparam int FLAG_ZERO   = 6;
	localparam int FLAG_PARITY = 2;
	localparam int FLAG_CARRY  = 0;

	localparam logic [15:0] RST_PROGRAM_COUNTER = 16'h0000;
	localparam logic [15:0] RST_STACK_POINTER   = 16'h0000;
	localparam logic [7:0]  RST_FLAGS           = 8'h00;
	localparam logic        SYNC_RST            = 1'b1;
	localparam int          CTRL_W_MIN          = 2;

	typedef enum logic [3:0] {
		OP_ABS_JUMP    = 4'h0,
		OP_ABS_JUMP_CC = 4'h1,
		OP_REL_JUMP    = 4'h2,
		OP_REL_JUMP_CC = 4'h3,
		OP_LOOP_BRANCH = 4'h4,
		OP_CALL        = 4'h5,
		OP_CALL_CC     = 4'h6,
		OP_EXIT        = 4'h7,
		OP_EXIT_CC     = 4'h8
	} pfc_op_e;

	typedef enum logic [2:0] {
		CC_NOT_ZERO  = 3'h0,
		CC_ZERO      = 3'h1,
		CC_NO_CARRY  = 3'h2,
		CC_CARRY     = 3'h3,
		CC_PAR_ODD   = 3'h4,
		CC_PAR_EVEN  = 3'h5,
		CC_POSITIVE  = 3'h6,
		CC_MINUS     = 3'h7
	} pfc_cc_e;

	localparam logic [2:0] REL_CC_MAX = 3'h3;
endpackage

// ===== hw/pfc_sync.sv
// Two-flop synchroniser, one per control input bit.
// Assumes inputs may change at any time relative to mclk.
module pfc_sync #(
	parameter int WIDTH = 2
) (
	input  wire logic             mclk,
	input  wire logic             reset_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta;

	if (WIDTH < 1) begin : g_chk
		$error("pfc_sync: WIDTH must be at least 1");
	end

	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		always_ff @(posedge mclk or negedge reset_n) begin
			if (!reset_n) begin
				meta[i]     <= pfc_pkg::SYNC_RST;
				sync_out[i] <= pfc_pkg::SYNC_RST;
			end else begin
				meta[i]     <= async_in[i];
				sync_out[i] <= meta[i];
			end
		end
	end

	AST_SYNC_DELAY: assert property (@(posedge mclk) disable iff (!reset_n)
		$past(reset_n, 2) |-> sync_out == $past(async_in, 2))
		else $error("synchroniser output is not the input two cycles late");
endmodule

// ===== hw/pfc_flow.sv
// Program flow unit: jumps, loop branch, calls and exits over an
// APB register file, stacking through an 8-bit memory port.
// Assumes memory answers after the strobe unless wait_n is held low.

// Operation
// - Conditional absolute jump loads target when condition holds, else continues
// - Conditional relative jump adds displacement when condition holds, else continues
// - Relative jumps test only four conditions; others test all eight
// - Loop branch decrements count; zero continues, else adds displacement
// - Call writes high byte at stack minus one, low at minus two
// - Conditional call acts as call when true, else continues
// - Conditional exit pops when true, else stack untouched and continues
// - Every control input is synchronised inside before use
module pfc_flow #(
	parameter int CTRL_W = 2
) (
	input  wire logic              mclk,
	input  wire logic              reset_n,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [CTRL_W-1:0] ctrl_in_n,
	output logic      [15:0]       mem_addr,
	output logic                   mem_rd_n,
	output logic                   mem_wr_n,
	input  wire logic [7:0]        data_in,
	output logic      [7:0]        data_out,
	output logic                   data_oe
);
	typedef enum logic [2:0] {
		ST_IDLE, ST_DECODE, ST_PUSH_HI, ST_PUSH_LO, ST_POP_LO, ST_POP_HI
	} pfc_state_e;

	pfc_state_e       st;
	logic [CTRL_W-1:0] ctrl_s;
	logic [7:0]       flags;
	logic [7:0]       loop_count;
	logic [15:0]      program_counter;
	logic [15:0]      stack_pointer;
	logic [15:0]      operand;
	logic [3:0]       op;
	logic [2:0]       cc;
	logic [7:0]       pop_lo;
	logic             pending, taken, bad_cond, busy, mapped, wr_en;
	logic             cmd_wr, cond_ok, go, mem_act, mem_done, wait_ok, hold;
	logic [15:0]      rel_tgt;
	logic [31:0]      next_rdata;

	if (CTRL_W < pfc_pkg::CTRL_W_MIN) begin : g_chk
		$error("pfc_flow: CTRL_W must be at least 2");
	end

	// Bit 0 is wait_n, bit 1 is hold_n; both may be asynchronous
	pfc_sync #(.WIDTH(CTRL_W)) u_sync (
		.mclk     (mclk),
		.reset_n  (reset_n),
		.async_in (ctrl_in_n),
		.sync_out (ctrl_s)
	);
	assign wait_ok = ctrl_s[0];
	assign hold    = !ctrl_s[1];

	assign busy    = (st != ST_IDLE) || pending;
	assign rel_tgt = 16'(program_counter + {{8{operand[7]}}, operand[7:0]});

	always_comb begin
		case (pfc_pkg::pfc_cc_e'(cc))
			pfc_pkg::CC_NOT_ZERO: cond_ok = !flags[pfc_pkg::FLAG_ZERO];
			pfc_pkg::CC_ZERO:     cond_ok = flags[pfc_pkg::FLAG_ZERO];
			pfc_pkg::CC_NO_CARRY: cond_ok = !flags[pfc_pkg::FLAG_CARRY];
			pfc_pkg::CC_CARRY:    cond_ok = flags[pfc_pkg::FLAG_CARRY];
			pfc_pkg::CC_PAR_ODD:  cond_ok = !flags[pfc_pkg::FLAG_PARITY];
			pfc_pkg::CC_PAR_EVEN: cond_ok = flags[pfc_pkg::FLAG_PARITY];
			pfc_pkg::CC_POSITIVE: cond_ok = !flags[pfc_pkg::FLAG_SIGN];
			default:              cond_ok = flags[pfc_pkg::FLAG_SIGN];
		endcase
	end

	// APB slave: zero wait states, read data latched in setup phase
	assign mapped  = paddr inside {pfc_pkg::OFS_COMMAND, pfc_pkg::OFS_STATUS,
		pfc_pkg::OFS_FLAGS, pfc_pkg::OFS_LOOP_COUNT, pfc_pkg::OFS_PROGRAM_COUNTER,
		pfc_pkg::OFS_STACK_POINTER, pfc_pkg::OFS_OPERAND};
	assign pready  = 1'b1;
	// Writes while busy would corrupt an operation in flight
	assign pslverr = psel && penable && (!mapped ||
		(pwrite && busy && paddr != pfc_pkg::OFS_STATUS));
	assign wr_en   = psel && penable && pwrite && !pslverr;
	assign cmd_wr  = wr_en && paddr == pfc_pkg::OFS_COMMAND;

	always_comb begin
		next_rdata = 32'h0000_0000;
		case (paddr)
			pfc_pkg::OFS_COMMAND: begin
				next_rdata[pfc_pkg::CMD_OP_LSB +: 4] = op;
				next_rdata[pfc_pkg::CMD_CC_LSB +: 3] = cc;
			end
			pfc_pkg::OFS_STATUS: begin
				next_rdata[pfc_pkg::STAT_BUSY]  = busy;
				next_rdata[pfc_pkg::STAT_TAKEN] = taken;
				next_rdata[pfc_pkg::STAT_BADCC] = bad_cond;
			end
			pfc_pkg::OFS_FLAGS:           next_rdata[7:0]  = flags;
			pfc_pkg::OFS_LOOP_COUNT:      next_rdata[7:0]  = loop_count;
			pfc_pkg::OFS_PROGRAM_COUNTER: next_rdata[15:0] = program_counter;
			pfc_pkg::OFS_STACK_POINTER:   next_rdata[15:0] = stack_pointer;
			pfc_pkg::OFS_OPERAND:         next_rdata[15:0] = operand;
			default:                      next_rdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			prdata <= 32'h0000_0000;
		else if (psel && !penable)
			prdata <= next_rdata;
	end

	// Software-owned registers, frozen while an operation runs
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			flags   <= pfc_pkg::RST_FLAGS;
			operand <= 16'h0000;
			op      <= 4'h0;
			cc      <= 3'h0;
		end else if (wr_en) begin
			case (paddr)
				pfc_pkg::OFS_FLAGS:   flags   <= pwdata[7:0];
				pfc_pkg::OFS_OPERAND: operand <= pwdata[15:0];
				pfc_pkg::OFS_COMMAND: begin
					op <= pwdata[pfc_pkg::CMD_OP_LSB +: 4];
					cc <= pwdata[pfc_pkg::CMD_CC_LSB +: 3];
				end
				default: ;
			endcase
		end
	end

	assign go = st == ST_IDLE && pending && !hold;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			pending <= 1'b0;
		else if (cmd_wr)
			pending <= 1'b1;
		else if (go)
			pending <= 1'b0;
	end

	assign mem_act  = !mem_rd_n || !mem_wr_n;
	assign mem_done = mem_act && wait_ok;
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			st <= ST_IDLE;
		else begin
			case (st)
				ST_IDLE:    if (go) st <= ST_DECODE;
				ST_DECODE:
					case (pfc_pkg::pfc_op_e'(op))
						pfc_pkg::OP_CALL:    st <= ST_PUSH_HI;
						pfc_pkg::OP_CALL_CC: st <= cond_ok ? ST_PUSH_HI : ST_IDLE;
						pfc_pkg::OP_EXIT:    st <= ST_POP_LO;
						pfc_pkg::OP_EXIT_CC: st <= cond_ok ? ST_POP_LO : ST_IDLE;
						default:             st <= ST_IDLE;
					endcase
				ST_PUSH_HI: if (mem_done) st <= ST_PUSH_LO;
				ST_PUSH_LO: if (mem_done) st <= ST_IDLE;
				ST_POP_LO:  if (mem_done) st <= ST_POP_HI;
				ST_POP_HI:  if (mem_done) st <= ST_IDLE;
				default:    st <= ST_IDLE;
			endcase
		end
	end

	// Memory strobes: launch on entry, release when wait_n allows
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			mem_addr <= 16'h0000;
			mem_rd_n <= 1'b1;
			mem_wr_n <= 1'b1;
			data_out <= 8'h00;
			data_oe  <= 1'b0;
		end else if (mem_done) begin
			mem_rd_n <= 1'b1;
			mem_wr_n <= 1'b1;
			data_oe  <= 1'b0;
		end else if (!mem_act) begin
			case (st)
				ST_PUSH_HI: begin
					mem_addr <= 16'(stack_pointer - 16'h0001);
					data_out <= program_counter[15:8];
					mem_wr_n <= 1'b0;
					data_oe  <= 1'b1;
				end
				ST_PUSH_LO: begin
					mem_addr <= 16'(stack_pointer - 16'h0002);
					data_out <= program_counter[7:0];
					mem_wr_n <= 1'b0;
					data_oe  <= 1'b1;
				end
				ST_POP_LO: begin
					mem_addr <= stack_pointer;
					mem_rd_n <= 1'b0;
				end
				ST_POP_HI: begin
					mem_addr <= 16'(stack_pointer + 16'h0001);
					mem_rd_n <= 1'b0;
				end
				default: ;
			endcase
		end
	end

	// Data bus is sampled only at the end of our own read strobe
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			pop_lo <= 8'h00;
		else if (st == ST_POP_LO && mem_done)
			pop_lo <= data_in;
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			program_counter <= pfc_pkg::RST_PROGRAM_COUNTER;
		else if (wr_en && paddr == pfc_pkg::OFS_PROGRAM_COUNTER)
			program_counter <= pwdata[15:0];
		else if (st == ST_DECODE) begin
			case (pfc_pkg::pfc_op_e'(op))
				pfc_pkg::OP_ABS_JUMP:    program_counter <= operand;
				pfc_pkg::OP_ABS_JUMP_CC: if (cond_ok) program_counter <= operand;
				pfc_pkg::OP_REL_JUMP: program_counter <= rel_tgt;
				pfc_pkg::OP_REL_JUMP_CC:
					if (cc <= pfc_pkg::REL_CC_MAX && cond_ok)
						program_counter <= rel_tgt;
				pfc_pkg::OP_LOOP_BRANCH:
					if (loop_count != 8'h01)
						program_counter <= rel_tgt;
				default: ;
			endcase
		end else if (st == ST_PUSH_LO && mem_done)
			program_counter <= operand;
		else if (st == ST_POP_HI && mem_done)
			program_counter <= {data_in, pop_lo};
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			stack_pointer <= pfc_pkg::RST_STACK_POINTER;
		else if (wr_en && paddr == pfc_pkg::OFS_STACK_POINTER)
			stack_pointer <= pwdata[15:0];
		else if (st == ST_PUSH_LO && mem_done)
			stack_pointer <= 16'(stack_pointer - 16'h0002);
		else if (st == ST_POP_HI && mem_done)
			stack_pointer <= 16'(stack_pointer + 16'h0002);
	end

	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n)
			loop_count <= 8'h00;
		else if (wr_en && paddr == pfc_pkg::OFS_LOOP_COUNT)
			loop_count <= pwdata[7:0];
		else if (st == ST_DECODE && op == pfc_pkg::OP_LOOP_BRANCH)
			loop_count <= 8'(loop_count - 8'h01);
	end

	// Outcome flags; cleared by the next command write
	always_ff @(posedge mclk or negedge reset_n) begin
		if (!reset_n) begin
			taken    <= 1'b0;
			bad_cond <= 1'b0;
		end else if (st == ST_DECODE) begin
			case (pfc_pkg::pfc_op_e'(op))
				pfc_pkg::OP_ABS_JUMP, pfc_pkg::OP_REL_JUMP,
				pfc_pkg::OP_CALL, pfc_pkg::OP_EXIT: taken <= 1'b1;
				pfc_pkg::OP_ABS_JUMP_CC, pfc_pkg::OP_CALL_CC,
				pfc_pkg::OP_EXIT_CC: taken <= cond_ok;
				pfc_pkg::OP_REL_JUMP_CC: begin
					taken    <= cc <= pfc_pkg::REL_CC_MAX && cond_ok;
					bad_cond <= cc > pfc_pkg::REL_CC_MAX;
				end
				pfc_pkg::OP_LOOP_BRANCH: taken <= loop_count != 8'h01;
				default: bad_cond <= 1'b1;
			endcase
		end else if (cmd_wr) begin
			taken    <= 1'b0;
			bad_cond <= 1'b0;
		end
	end

	default clocking cb @(posedge mclk); endclocking
	default disable iff (!reset_n);

	AST_ABS_TAKEN: assert property (st == ST_DECODE && op == pfc_pkg::OP_ABS_JUMP_CC
		&& cond_ok |=> program_counter == $past(operand))
		else $error("absolute jump did not load target");
	AST_ABS_SKIP: assert property (st == ST_DECODE && op == pfc_pkg::OP_ABS_JUMP_CC
		&& !cond_ok |=> program_counter == $past(program_counter))
		else $error("untaken absolute jump moved the counter");
	AST_REL_TAKEN: assert property (st == ST_DECODE && op == pfc_pkg::OP_REL_JUMP_CC
		&& cc <= pfc_pkg::REL_CC_MAX && cond_ok
		|=> program_counter == 16'($past(program_counter)
			+ {{8{$past(operand[7])}}, $past(operand[7:0])}))
		else $error("relative jump target wrong");
	AST_REL_BADCC: assert property (st == ST_DECODE && op == pfc_pkg::OP_REL_JUMP_CC
		&& cc > pfc_pkg::REL_CC_MAX |=> bad_cond && $stable(program_counter))
		else $error("relative jump accepted an illegal condition");
	AST_LOOP_END: assert property (st == ST_DECODE && op == pfc_pkg::OP_LOOP_BRANCH
		&& loop_count == 8'h01 |=> loop_count == 8'h00 && $stable(program_counter))
		else $error("loop branch at count one did not fall through");
	AST_PUSH_HI: assert property (st == ST_PUSH_HI && !mem_wr_n
		|-> mem_addr == 16'(stack_pointer - 16'h0001) && data_out == program_counter[15:8])
		else $error("high byte push wrong");
	AST_PUSH_LO: assert property (st == ST_PUSH_LO && !mem_wr_n
		|-> mem_addr == 16'(stack_pointer - 16'h0002) && data_out == program_counter[7:0])
		else $error("low byte push wrong");
	AST_CALL_SKIP: assert property (st == ST_DECODE && op == pfc_pkg::OP_CALL_CC
		&& !cond_ok |=> (st == ST_IDLE && mem_wr_n) [*2])
		else $error("false call touched the stack");
	AST_EXIT_SKIP: assert property (st == ST_DECODE && op == pfc_pkg::OP_EXIT_CC
		&& !cond_ok |=> $stable(stack_pointer) && mem_rd_n && st == ST_IDLE)
		else $error("false exit touched the stack");
	AST_OE_WRITE: assert property (data_oe |-> !mem_wr_n && mem_rd_n)
		else $error("data bus driven outside a write");

	COV_CALL: cover property (st == ST_PUSH_LO && mem_done);
	COV_EXIT: cover property (st == ST_POP_HI && mem_done);
	COV_LOOP: cover property (st == ST_DECODE && op == pfc_pkg::OP_LOOP_BRANCH);
	COV_WAIT: cover property (mem_act && !wait_ok);
endmodule

// ===== dv/pfc_mem_model.sv
// Byte memory and wait source on the flow unit's stacking port.
// Assumes active-low strobes that stay low until the access ends.
module pfc_mem_model (
	input  wire logic        mclk,
	input  wire logic        slow,
	input  wire logic [15:0] mem_addr,
	input  wire logic        mem_rd_n,
	input  wire logic        mem_wr_n,
	input  wire logic [7:0]  data_out,
	output logic      [7:0]  data_in,
	output logic             wait_n
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] mem [256] = '{default: 8'h00};
	logic [7:0] last      = 8'h00;
	logic       wait_q    = 1'b1;
	int         stall     = 0;
	// Released bus shows the inverse so a stale byte is never mistaken
	// Bytes only on our read strobe; no acknowledge, the unit has no fetch strobe
	assign data_in = !mem_rd_n ? mem[mem_addr[7:0]] : ~last;
	assign wait_n  = wait_q;
	always @(posedge mclk) begin
		if (!mem_wr_n)
			mem[mem_addr[7:0]] <= data_out;
		if (!mem_rd_n)
			last <= data_in;
		if (mem_rd_n && mem_wr_n)
			stall <= 0;
		else if (slow && stall < 3)
			stall <= stall + 1;
		// Slow mode pulls wait low early in each strobe; the unit sees it two
		// cycles late, so no access stretches
		wait_q <= !(slow && !(mem_rd_n && mem_wr_n) && stall < 3);
	end
endmodule

// ===== dv/test_program_flow_control.sv
// Self-checking bench of the flow unit over APB.
// Assumes the memory model on the byte port and one 20 MHz clock.
module test_program_flow_control;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk;
	logic        reset_n;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [7:0]  paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        hold_n;
	logic        wait_n;
	logic        slow;
	logic [15:0] mem_addr;
	logic        mem_rd_n;
	logic        mem_wr_n;
	logic [7:0]  data_in;
	logic [7:0]  data_out;
	logic [31:0] q;
	logic        e;
	logic [7:0]  f;
	logic [2:0]  c;
	int          mismatches;
	int          check_count;
	logic [3:0]  so [6] = '{pfc_pkg::OP_CALL, pfc_pkg::OP_CALL_CC, pfc_pkg::OP_CALL_CC,
		pfc_pkg::OP_EXIT_CC, pfc_pkg::OP_EXIT, pfc_pkg::OP_EXIT_CC};
	logic [2:0]  sc [6] = '{3'h0, pfc_pkg::CC_ZERO, pfc_pkg::CC_NOT_ZERO,
		pfc_pkg::CC_ZERO, 3'h0, pfc_pkg::CC_NOT_ZERO};
	logic [15:0] st [6] = '{16'h4000, 16'h1111, 16'h5678, 16'h2222, 16'h0000, 16'h0000};
	logic [31:0] sx [6] = '{32'h400000fe, 32'h400000fe, 32'h567800fc,
		32'h567800fc, 32'h400000fe, 32'h12340100};

	pfc_flow i_dut (.mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .ctrl_in_n({hold_n, wait_n}),
		.mem_addr(mem_addr), .mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n),
		.data_in(data_in), .data_out(data_out), .data_oe());
	pfc_mem_model i_mem (.mclk(mclk), .slow(slow), .mem_addr(mem_addr),
		.mem_rd_n(mem_rd_n), .mem_wr_n(mem_wr_n), .data_out(data_out),
		.data_in(data_in), .wait_n(wait_n));

	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	task automatic summarize();
		if (mismatches == 0 && check_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// Entered just after an edge; leaves one idle edge before the next setup
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge mclk);
		penable <= 1'b1;
		@(posedge mclk);
		while (pready !== 1'b1 && n < 50) begin
			@(posedge mclk);
			n++;
		end
		chk(32'(pready), 32'h1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		chk(32'(e), 32'h0);
	endtask

	task automatic rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask

	task automatic issue(input logic [3:0] op, input logic [2:0] cc, input logic [15:0] v);
		wr(pfc_pkg::OFS_OPERAND, {16'h0000, v});
		wr(pfc_pkg::OFS_COMMAND, {25'h0, cc, op});
	endtask

	task automatic wait_idle();
		int n;
		n = 0;
		rd(pfc_pkg::OFS_STATUS);
		while (q[pfc_pkg::STAT_BUSY] !== 1'b0 && n < 100) begin
			rd(pfc_pkg::OFS_STATUS);
			n++;
		end
		chk(32'(n < 100), 32'h1);
	endtask

	task automatic setup(input logic [15:0] pc, input logic [15:0] sp, input logic [7:0] fl);
		wr(pfc_pkg::OFS_PROGRAM_COUNTER, {16'h0000, pc});
		wr(pfc_pkg::OFS_STACK_POINTER, {16'h0000, sp});
		wr(pfc_pkg::OFS_FLAGS, {24'h0, fl});
	endtask

	function automatic logic cond(input logic [2:0] cc, input logic [7:0] fl);
		case (cc)
			3'h0: return !fl[pfc_pkg::FLAG_ZERO];
			3'h1: return fl[pfc_pkg::FLAG_ZERO];
			3'h2: return !fl[pfc_pkg::FLAG_CARRY];
			3'h3: return fl[pfc_pkg::FLAG_CARRY];
			3'h4: return !fl[pfc_pkg::FLAG_PARITY];
			3'h5: return fl[pfc_pkg::FLAG_PARITY];
			3'h6: return !fl[pfc_pkg::FLAG_SIGN];
			default: return fl[pfc_pkg::FLAG_SIGN];
		endcase
	endfunction

	initial begin
		#1000000;
		mismatches++;
		summarize();
	end

	initial begin
		mismatches = 0;
		check_count = 0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		hold_n = 1'b1;
		slow = 1'b0;
		reset_n = 1'b0;
		repeat (3) @(posedge mclk);
		reset_n <= 1'b1;
		@(posedge mclk);
		rd(pfc_pkg::OFS_PROGRAM_COUNTER);
		chk(q, {16'h0, pfc_pkg::RST_PROGRAM_COUNTER});
		rd(pfc_pkg::OFS_STACK_POINTER);
		chk(q, {16'h0, pfc_pkg::RST_STACK_POINTER});
		rd(8'h1c);
		chk({q[30:0], e}, 32'h1);
		// Two flag sets cover every condition both ways
		for (int k = 0; k < 32; k++) begin
			f = k[3] ? 8'h84 : 8'h41;
			c = k[2:0];
			setup(16'h1000, 16'h0100, f);
			issue(k[4] ? pfc_pkg::OP_REL_JUMP_CC : pfc_pkg::OP_ABS_JUMP_CC, c, 16'h20f0);
			wait_idle();
			rd(pfc_pkg::OFS_PROGRAM_COUNTER);
			if (!k[4])
				chk(q, cond(c, f) ? 32'h20f0 : 32'h1000);
			else
				chk(q, (cond(c, f) && c <= 3) ? 32'h0ff0 : 32'h1000);
			rd(pfc_pkg::OFS_STATUS);
			chk(32'(q[2:1]), k[4] && c > 3 ? 32'h2 : 32'(cond(c, f)));
		end
		issue(pfc_pkg::OP_REL_JUMP, 3'h0, 16'h007f);
		wait_idle();
		rd(pfc_pkg::OFS_PROGRAM_COUNTER);
		chk(q, 32'h107f);
		issue(pfc_pkg::OP_ABS_JUMP, 3'h0, 16'hbeef);
		wait_idle();
		rd(pfc_pkg::OFS_PROGRAM_COUNTER);
		chk(q, 32'hbeef);
		for (int k = 1; k < 3; k++) begin
			setup(16'h1000, 16'h0100, 8'h00);
			wr(pfc_pkg::OFS_LOOP_COUNT, 32'(k));
			issue(pfc_pkg::OP_LOOP_BRANCH, 3'h0, 16'h0005);
			wait_idle();
			rd(pfc_pkg::OFS_PROGRAM_COUNTER);
			chk(q, k == 1 ? 32'h1000 : 32'h1005);
			rd(pfc_pkg::OFS_LOOP_COUNT);
			chk(q, 32'(k - 1));
		end
		slow <= 1'b1;
		setup(16'h1234, 16'h0100, 8'h00);
		for (int k = 0; k < 6; k++) begin
			if (k == 3)
				hold_n <= 1'b0;
			issue(so[k], sc[k], st[k]);
			if (k == 3) begin
				apb(1'b1, pfc_pkg::OFS_OPERAND, 32'h0);
				chk(32'(e), 32'h1);
				rd(pfc_pkg::OFS_STATUS);
				chk(32'(q[0]), 32'h1);
				hold_n <= 1'b1;
			end
			wait_idle();
			rd(pfc_pkg::OFS_STACK_POINTER);
			chk(q, {16'h0, sx[k][15:0]});
			rd(pfc_pkg::OFS_PROGRAM_COUNTER);
			chk(q, {16'h0, sx[k][31:16]});
		end
		chk({i_mem.mem[255], i_mem.mem[254], i_mem.mem[253], i_mem.mem[252]},
			32'h12344000);
		summarize();
	end
endmodule
